// >>> hw/iesq_defs.svh
/*
  timing-free constants of the interrupt entry/exit sequencer: stack frame
  size, vector table base, reset values and bit positions.
  assumes: included by bare name from design and verification files.
*/
`ifndef IESQ_DEFS_SVH
`define IESQ_DEFS_SVH

// ----------------------------------------------------------------------
// condition code layout
// ----------------------------------------------------------------------
`define IESQ_CCR_IMASK_BIT  3
`define IESQ_CCR_RESET      8'h68

// ----------------------------------------------------------------------
// stack and vectors
// ----------------------------------------------------------------------
`define IESQ_FRAME_BYTES    3'h5
`define IESQ_QUEUE_BYTES    2'h3
`define IESQ_SP_RESET       16'h00FF
`define IESQ_VEC_TOP        16'hFFFE
`define IESQ_SWI_VEC        16'hFFFC

`endif

// >>> hw/iesq_pkg.sv
/*
  types of the interrupt entry/exit sequencer.
  assumes: compiled before every design file.
*/
package iesq_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_PUSH,
    ST_VECH,
    ST_VECL,
    ST_FILL,
    ST_POP
  } iesq_state_type;

endpackage : iesq_pkg

// >>> hw/iesq_prio.sv
/*
  fixed priority picker: lowest request index wins.
  assumes: requests are stable in the cycle they are sampled.
*/
module iesq_prio #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  input  wire logic [N-1:0]  req,    // pending requests
  output logic               any,    // some request pending
  output logic [IW-1:0]      idx     // winner index
);

  // ----------------------------------------------------------------------
  // scan from the top so the lowest index is left standing
  // ----------------------------------------------------------------------
  always_comb begin
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
      end
    end
  end

  assign any = |req;

endmodule : iesq_prio

// >>> hw/iesq_stack.sv
/*
  byte-wide stack memory in flip-flops, grows downward.
  assumes: one access per cycle, address within depth.
*/
module iesq_stack #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_sys,   // core clock
  input  wire logic          wr_en,     // write strobe
  input  wire logic [AW-1:0] addr,      // byte address
  input  wire logic [7:0]    wdata,     // byte written
  output logic      [7:0]    rdata      // byte read, registered
);

  logic [7:0] mem_ff [DEPTH];

  // ----------------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_ff[addr] <= wdata;
    end
    rdata <= mem_ff[addr];
  end

endmodule : iesq_stack

// >>> hw/iesq_seq.sv
/*
  interrupt entry and return sequencer of an 8-bit core.
  assumes: the core pulses instr_done at each instruction boundary and
  holds next_pc there; vector memory answers in the same cycle; request
  lines come from synchronous peripheral logic on clk_sys.
*/
// Behaviour
// - after reset the global mask bit is set
// - finish the current instruction before entering the sequence
// - hardware entry uses the same steps as the software interrupt
// - push registers first, then set the mask bit
// - fetch vector of highest-priority source pending then
// - fill instruction queue with three bytes from the vector address
// - mask cleared inside a service routine allows nested interrupts
// - return pops condition codes, accumulator, low index, counter
// - high index byte is neither saved nor restored
// - several pending at unmask: highest priority served first
// - pointer addresses free byte; push counter low first, codes last
// - after stacking pointer is codes address minus one
// - stacked counter is the next main-program instruction address
`include "iesq_defs.svh"
module iesq_seq #(
  parameter int NSRC = 8,             // interrupt sources
  parameter int IW   = 3,             // source index width
  parameter int SAW  = 8              // stack address width
) (
  input  wire logic            clk_sys,         // core clock
  input  wire logic            rst,             // sync reset, high
  input  wire logic [NSRC-1:0] irq_req,         // source requests
  input  wire logic            instr_done,      // instruction boundary
  input  wire logic [15:0]     next_pc,         // next main pc
  input  wire logic [7:0]      acc_in,          // accumulator now
  input  wire logic [7:0]      xlo_in,          // low index now
  input  wire logic [7:0]      ccr_in,          // condition codes now
  input  wire logic            ccr_load,        // core writes ccr
  input  wire logic            swi_exec,        // software interrupt
  input  wire logic            rti_exec,        // return instruction
  input  wire logic [7:0]      vec_rdata,       // vector memory byte
  output logic [15:0]          vec_addr,        // vector memory addr
  output logic                 core_hold,       // stall the core
  output logic                 irq_ack,         // hardware entry taken, pulse
  output logic [IW-1:0]        irq_ack_idx,     // source acknowledged
  output logic [7:0]           ccr_out,         // condition codes
  output logic [15:0]          pc_out,          // program counter
  output logic [7:0]           acc_out,         // restored accumulator
  output logic [7:0]           xlo_out,         // restored low index
  output logic                 regs_load,       // restore pulse
  output logic [15:0]          fetch_addr,      // queue fill address
  output logic                 fetch_req,       // queue fill strobe
  output logic [SAW-1:0]       sp_out           // stack pointer
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  iesq_pkg::iesq_state_type state_ff, nxt_state;
  logic [7:0]     ccr_ff;
  logic [SAW-1:0] sp_ff;
  logic [2:0]     cnt_ff;
  logic [15:0]    pc_ff;
  logic [15:0]    vaddr_ff;
  logic [7:0]     acc_ff;
  logic [7:0]     xlo_ff;
  logic [7:0]     ccr_snap_ff;
  logic           is_swi_ff;
  logic           ack_ff;
  logic           rload_ff;
  logic [IW-1:0]  ack_idx_ff;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire            imask   = ccr_ff[`IESQ_CCR_IMASK_BIT];
  wire            pend_any;
  wire [IW-1:0]   pend_idx;
  wire            run     = (state_ff == iesq_pkg::ST_RUN);
  wire            take_hw = run && instr_done && pend_any && !imask;
  wire            take_sw = run && swi_exec && !take_hw;
  wire            take    = take_hw || take_sw;
  wire            start_rt = run && rti_exec && !take;
  wire            push_last = (cnt_ff == `IESQ_FRAME_BYTES - 3'h1);
  wire            pop_last  = (cnt_ff == `IESQ_FRAME_BYTES);
  wire            fill_last = (cnt_ff == 3'(`IESQ_QUEUE_BYTES) - 3'h1);
  wire [15:0]     vec_base;
  wire [7:0]      push_byte;
  wire            push_wr  = (state_ff == iesq_pkg::ST_PUSH);
  wire [SAW-1:0]  pop_addr = sp_ff + SAW'(1);
  wire [SAW-1:0]  stk_addr = push_wr ? sp_ff : pop_addr;
  wire [7:0]      stk_rdata;

  // priority among pending sources, lowest index highest
  iesq_prio #(.N(NSRC), .IW(IW)) u_prio (
    .req (irq_req),
    .any (pend_any),
    .idx (pend_idx)
  );

  // vector slots two bytes each, downward from the top
  assign vec_base = is_swi_ff ? `IESQ_SWI_VEC
                  : `IESQ_VEC_TOP - 16'h0002
                    - {12'h000, ack_idx_ff, 1'b0};

  // frame order: pcl, pch, xlo, acc, ccr; high index skipped
  assign push_byte = (cnt_ff == 3'h0) ? pc_ff[7:0]
                   : (cnt_ff == 3'h1) ? pc_ff[15:8]
                   : (cnt_ff == 3'h2) ? xlo_ff
                   : (cnt_ff == 3'h3) ? acc_ff
                   : ccr_snap_ff;

  iesq_stack #(.DEPTH(1 << SAW), .AW(SAW)) u_stack (
    .clk_sys (clk_sys),
    .wr_en   (push_wr),
    .addr    (stk_addr),
    .wdata   (push_byte),
    .rdata   (stk_rdata)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      iesq_pkg::ST_RUN: begin
        if (take) begin
          nxt_state = iesq_pkg::ST_PUSH;
        end else if (start_rt) begin
          nxt_state = iesq_pkg::ST_POP;
        end
      end
      iesq_pkg::ST_PUSH: begin
        if (push_last) begin
          nxt_state = iesq_pkg::ST_VECH;
        end
      end
      iesq_pkg::ST_VECH: nxt_state = iesq_pkg::ST_VECL;
      iesq_pkg::ST_VECL: nxt_state = iesq_pkg::ST_FILL;
      iesq_pkg::ST_FILL: begin
        if (fill_last) begin
          nxt_state = iesq_pkg::ST_RUN;
        end
      end
      iesq_pkg::ST_POP: begin
        if (pop_last) begin
          nxt_state = iesq_pkg::ST_RUN;
        end
      end
      default: nxt_state = iesq_pkg::ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer and counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= iesq_pkg::ST_RUN;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (state_ff != nxt_state) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // snapshot of the registers at the boundary
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_ff       <= 16'h0000;
      acc_ff      <= 8'h00;
      xlo_ff      <= 8'h00;
      ccr_snap_ff <= 8'h00;
      is_swi_ff   <= 1'b0;
      ack_idx_ff  <= '0;
    end else if (take) begin
      pc_ff       <= next_pc;
      acc_ff      <= acc_in;
      xlo_ff      <= xlo_in;
      ccr_snap_ff <= ccr_ff;
      is_swi_ff   <= take_sw;
      ack_idx_ff  <= pend_idx;
    end
  end

  // ----------------------------------------------------------------------
  // stack pointer: free byte before, one below ccr slot after
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sp_ff <= SAW'(`IESQ_SP_RESET);
    end else if (push_wr) begin
      sp_ff <= sp_ff - SAW'(1);
    end else if (state_ff == iesq_pkg::ST_POP && !pop_last) begin
      sp_ff <= pop_addr;
    end
  end

  // ----------------------------------------------------------------------
  // condition codes, mask set at reset and after stacking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ccr_ff <= `IESQ_CCR_RESET;
    end else if (state_ff == iesq_pkg::ST_PUSH && push_last) begin
      ccr_ff[`IESQ_CCR_IMASK_BIT] <= 1'b1;
    end else if (state_ff == iesq_pkg::ST_POP && cnt_ff == 3'h1) begin
      ccr_ff <= stk_rdata;
    end else if (run && ccr_load) begin
      ccr_ff <= ccr_in;
    end
  end

  // ----------------------------------------------------------------------
  // vector read and queue fill
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vaddr_ff <= 16'h0000;
    end else if (state_ff == iesq_pkg::ST_VECH) begin
      vaddr_ff[15:8] <= vec_rdata;
    end else if (state_ff == iesq_pkg::ST_VECL) begin
      vaddr_ff[7:0] <= vec_rdata;
    end
  end

  assign vec_addr   = (state_ff == iesq_pkg::ST_VECL) ? vec_base + 16'h0001
                                                      : vec_base;
  assign fetch_req  = (state_ff == iesq_pkg::ST_FILL);
  assign fetch_addr = vaddr_ff + {13'h0000, cnt_ff};

  // ----------------------------------------------------------------------
  // restore on return, pops ccr, acc, xlo, pch, pcl
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_out  <= 8'h00;
      xlo_out  <= 8'h00;
      pc_out   <= 16'h0000;
      rload_ff <= 1'b0;
    end else begin
      rload_ff <= 1'b0;
      if (state_ff == iesq_pkg::ST_POP) begin
        if (cnt_ff == 3'h2) acc_out <= stk_rdata;
        if (cnt_ff == 3'h3) xlo_out <= stk_rdata;
        if (cnt_ff == 3'h4) pc_out[15:8] <= stk_rdata;
        if (pop_last) begin
          pc_out[7:0] <= stk_rdata;
          rload_ff    <= 1'b1;
        end
      end else if (state_ff == iesq_pkg::ST_VECL) begin
        pc_out <= {vaddr_ff[15:8], vec_rdata};
      end
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take_hw;
    end
  end

  assign irq_ack     = ack_ff;
  assign irq_ack_idx = ack_idx_ff;
  assign regs_load   = rload_ff;
  assign ccr_out     = ccr_ff;
  assign sp_out      = sp_ff;
  assign core_hold   = !run;

endmodule : iesq_seq

// >>> verif/iesq_seq_monitor.sv
/* checker of the sequencer ports, bound into iesq_seq.
   assumes: one clock, rst synchronous high. */
`include "iesq_defs.svh"
module iesq_seq_monitor #(
  parameter int NSRC = 8,
  parameter int IW   = 3,
  parameter int SAW  = 8
) (
  input wire logic            clk_sys,     // clock
  input wire logic            rst,         // reset
  input wire logic [NSRC-1:0] irq_req,     // requests
  input wire logic            instr_done,  // boundary
  input wire logic            swi_exec,    // soft entry
  input wire logic            rti_exec,    // return
  input wire logic            core_hold,   // stall
  input wire logic            irq_ack,     // taken
  input wire logic [IW-1:0]   irq_ack_idx, // source
  input wire logic [7:0]      ccr_out,     // codes
  input wire logic [SAW-1:0]  sp_out,      // pointer
  input wire logic            fetch_req,   // fill
  input wire logic [15:0]     fetch_addr,  // fill addr
  input wire logic            regs_load    // restored
);
  timeunit 1ns;
  timeprecision 1ps;
  // winner of the requests seen one cycle ago
  logic [IW-1:0] lo_ff;
  logic [IW-1:0] nxt_lo;
  always_comb begin
    nxt_lo = '0;
    for (int i = NSRC - 1; i >= 0; i--) if (irq_req[i]) nxt_lo = IW'(i);
  end
  always_ff @(posedge clk_sys) lo_ff <= nxt_lo;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // entry steps
  sequence push_s; !ccr_out[3] [*5]; endsequence
  sequence entry_s; core_hold [*8] ##1 core_hold ##1 core_hold; endsequence

  ack_boundary_a: assert property (irq_ack |-> $past(instr_done | swi_exec))
    else $error("entry taken off a boundary");
  entry_span_a: assert property (irq_ack |-> entry_s ##1 !core_hold)
    else $error("entry length wrong");
  mask_order_a: assert property (irq_ack && !ccr_out[3] |-> push_s ##1 ccr_out[3])
    else $error("mask not set right after stacking");
  stack_drop_a: assert property (irq_ack |-> ##5 sp_out == SAW'($past(sp_out, 5) - 5))
    else $error("stack pointer not five lower");
  prio_pick_a: assert property (irq_ack && !$past(swi_exec) |-> irq_ack_idx == lo_ff)
    else $error("wrong source taken");
  fill_three_a: assert property ($rose(fetch_req) |-> fetch_req [*3] ##1 !fetch_req)
    else $error("queue fill not three");
  fill_step_a: assert property (fetch_req && $past(fetch_req) |->
    fetch_addr == 16'($past(fetch_addr) + 16'h0001))
    else $error("fill address not stepping");
  reset_mask_a: assert property ($fell(rst) |->
    ccr_out == `IESQ_CCR_RESET && sp_out == SAW'(`IESQ_SP_RESET))
    else $error("reset values wrong");
  masked_quiet_a: assert property (instr_done && ccr_out[3] && !swi_exec &&
    !core_hold |=> !irq_ack)
    else $error("masked request taken");
  return_pulse_a: assert property (rti_exec && !core_hold && !swi_exec &&
    !instr_done |-> ##[6:8] regs_load)
    else $error("return never restored");
endmodule : iesq_seq_monitor

bind iesq_seq iesq_seq_monitor #(.NSRC(NSRC), .IW(IW), .SAW(SAW))
  iesq_seq_monitor_inst (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req),
  .instr_done(instr_done), .swi_exec(swi_exec), .rti_exec(rti_exec),
  .core_hold(core_hold), .irq_ack(irq_ack), .irq_ack_idx(irq_ack_idx),
  .ccr_out(ccr_out), .sp_out(sp_out), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .regs_load(regs_load));

// >>> verif/iesq_vec_mem.sv
/* vector memory model for the sequencer.
   assumes: combinational read of one byte. */
module iesq_vec_mem (
  input  wire logic [15:0] vec_addr,  // byte address
  output logic      [7:0]  vec_rdata  // byte returned
);
  timeunit 1ns;
  timeprecision 1ps;
  // low byte echoes the address so every vector differs
  assign vec_rdata = vec_addr[0] ? vec_addr[7:0] : 8'hC0;
endmodule : iesq_vec_mem

// >>> verif/iesq_seq_test.sv
/* self-checking bench of iesq_seq with the vector memory model.
   assumes: design, package and iesq_defs.svh compiled first. */
`include "iesq_defs.svh"
module iesq_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, instr_done, ccr_load, swi_exec, rti_exec;
  logic        core_hold, irq_ack, regs_load, fetch_req, fq_prev;
  logic [7:0]  irq_req, acc_in, xlo_in, ccr_in, vec_rdata, ccr_m;
  logic [7:0]  acc_out, xlo_out, ccr_out, sp_out;
  logic [15:0] next_pc, vec_addr, pc_out, fetch_addr;
  logic [2:0]  irq_ack_idx;
  logic [2:0]  q_ack[$];
  logic [15:0] q_vec[$];
  logic [39:0] q_ret[$];
  logic [39:0] stk[$];
  int          fails, tests_run, n;

  iesq_seq iesq_seq_inst (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req),
    .instr_done(instr_done), .next_pc(next_pc), .acc_in(acc_in),
    .xlo_in(xlo_in), .ccr_in(ccr_in), .ccr_load(ccr_load),
    .swi_exec(swi_exec), .rti_exec(rti_exec), .vec_rdata(vec_rdata),
    .vec_addr(vec_addr), .core_hold(core_hold), .irq_ack(irq_ack),
    .irq_ack_idx(irq_ack_idx), .ccr_out(ccr_out), .pc_out(pc_out),
    .acc_out(acc_out), .xlo_out(xlo_out), .regs_load(regs_load),
    .fetch_addr(fetch_addr), .fetch_req(fetch_req), .sp_out(sp_out));
  iesq_vec_mem iesq_vec_mem_inst (.vec_addr(vec_addr), .vec_rdata(vec_rdata));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // bounded wait for the core to run again
  task automatic wait_free(output int cnt);
    cnt = 0;
    while (core_hold !== 1'b0) begin
      tick();
      cnt++;
      if (cnt > 40) begin
        fails++;
        report_and_stop();
      end
    end
  endtask : wait_free

  // one entry, hardware (sw = 0) or software (sw = 1)
  task automatic enter(logic sw, logic [7:0] req);
    logic [2:0] idx;
    logic [7:0] sp0;
    logic [15:0] vx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) if (req[i]) idx = 3'(i);
    if (!sw) begin
      ccr_in = 8'($urandom) & 8'hF7;
      ccr_load = 1'b1;
      tick();
      ccr_load = 1'b0;
      ccr_m = ccr_in;
      irq_req = req;
    end
    acc_in = 8'($urandom);
    xlo_in = 8'($urandom);
    next_pc = 16'($urandom);
    repeat (3) tick();
    chk("hold before boundary", 1'b0, core_hold);
    sp0 = sp_out;
    stk.push_back({ccr_m, acc_in, xlo_in, next_pc});
    vx = {8'hC0, 8'(8'hFD - {idx, 1'b0})};
    q_vec.push_back(vx);
    if (sw) swi_exec = 1'b1;
    else instr_done = 1'b1;
    if (!sw) q_ack.push_back(idx);
    tick();
    instr_done = 1'b0;
    swi_exec = 1'b0;
    wait_free(n);
    chk("entry cycles", 10, n);
    chk("mask after entry", 1'b1, ccr_out[3]);
    chk("stack pointer", 8'(sp0 - 8'h05), sp_out);
    chk("entry pc", vx, pc_out);
    ccr_m = ccr_m | 8'h08;
    irq_req = 8'h00;
  endtask : enter

  task automatic ret();
    logic [39:0] f;
    f = stk.pop_back();
    q_ret.push_back(f);
    rti_exec = 1'b1;
    tick();
    rti_exec = 1'b0;
    wait_free(n);
    repeat (3) tick();
    ccr_m = f[39:32];
  endtask : ret

  // watcher: takes the oldest note whenever a result shows
  always @(posedge clk_sys) begin
    if (irq_ack === 1'b1 && q_ack.size() > 0)
      chk("ack source", q_ack.pop_front(), irq_ack_idx);
    else if (irq_ack === 1'b1) chk("extra ack", 1'b0, 1'b1);
    if (fetch_req === 1'b1 && fq_prev !== 1'b1)
      chk("fill start", q_vec.pop_front(), fetch_addr);
    if (regs_load === 1'b1 && q_ret.size() > 0)
      chk("frame", q_ret.pop_front(), {ccr_out, acc_out, xlo_out, pc_out});
    else if (regs_load === 1'b1) chk("extra restore", 1'b0, 1'b1);
    fq_prev = fetch_req;
  end

  initial begin
    void'($urandom(7544));
    {rst, instr_done, ccr_load, swi_exec, rti_exec} = 5'h10;
    {irq_req, acc_in, xlo_in, ccr_in, next_pc} = '0;
    {fails, tests_run, fq_prev, ccr_m} = {32'h0, 32'h0, 1'b0, 8'h68};
    repeat (12) tick();
    rst = 1'b0;
    chk("reset codes", `IESQ_CCR_RESET, ccr_out);
    chk("reset pointer", 8'(`IESQ_SP_RESET), sp_out);
    irq_req = 8'hFF;
    instr_done = 1'b1;
    tick();
    instr_done = 1'b0;
    repeat (3) tick();
    chk("masked request", 1'b0, core_hold);
    irq_req = 8'h00;
    // nested entries, each hardware one unmasking before its request
    for (int k = 0; k < 3; k++) enter(1'b0, 8'($urandom_range(255, 1)));
    enter(1'b1, 8'h00);
    repeat (4) ret();
    enter(1'b0, 8'h80);
    ret();
    chk("notes left", 0, q_ack.size() + q_vec.size() + q_ret.size());
    report_and_stop();
  end
endmodule : iesq_seq_test
